/* File: hw/keypad_pkg.sv */
package keypad_pkg;
    // Register pointer values.
    localparam logic [7:0] CFG_ADDR = 8'h01;
    localparam logic [7:0] STAT_ADDR = 8'h02;
    localparam logic [7:0] CNT_ADDR = 8'h03;
    localparam logic [7:0] EVT_ADDR = 8'h04;
    // Configuration bit positions.
    localparam int AUTO_BIT = 7;
    localparam int LOCKGPI_BIT = 6;
    localparam int OVMODE_BIT = 5;
    localparam int INTMODE_BIT = 4;
    localparam int OVIEN_BIT = 3;
    localparam int LKIEN_BIT = 2;
    localparam int GPIEN_BIT = 1;
    localparam int KEYIEN_BIT = 0;
    localparam logic [7:0] CFG_RESET = 8'h00;
    // Status bit positions.
    localparam int COMBO_BIT = 4;
    localparam int OVF_BIT = 3;
    localparam int LOCK_BIT = 2;
    localparam int GPI_BIT = 1;
    localparam int KEY_BIT = 0;
    // Matrix and store geometry.
    localparam int ROWS = 8;
    localparam int COLS = 10;
    localparam int KEYS = ROWS * COLS;
    localparam int DEPTH = 10;
    localparam logic [6:0] COMBO_A = 7'h00;
    localparam logic [6:0] COMBO_B = 7'h0A;
    localparam logic [6:0] COMBO_C = 7'h14;
    localparam logic [7:0] GPI_CODE = 8'h62;
    localparam logic [6:0] DEV_ADDR = 7'h2A;
    // Timing.
    localparam int CLK_MHZ = 100;
    localparam int SCAN_MS = 25;
    localparam int SCAN_CYC = SCAN_MS * 1000 * CLK_MHZ;
    localparam int REARM_US = 50;
    localparam int REARM_CYC = REARM_US * CLK_MHZ;
    localparam logic [3:0] SETTLE_CYC = 4'h4;

    typedef enum logic [2:0] {
        I_IDLE = 3'b000,
        I_ADDR = 3'b001,
        I_PTR  = 3'b010,
        I_WR   = 3'b011,
        I_RD   = 3'b100
    } i2c_st_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] code;
    } event_t;
endpackage : keypad_pkg

/* File: hw/keypad_event_fifo_control.sv */
`timescale 1ns/1ps
`default_nettype none
module keypad_event_fifo_control
    import keypad_pkg::*;
#(
    parameter int SCAN_CYCLES  = SCAN_CYC,
    parameter int REARM_CYCLES = REARM_CYC
) (
    input  wire logic            mclk_i,
    input  wire logic            rst_b_i,
    input  wire logic            scl_i,
    input  wire logic            sda_i,
    output logic                 sda_o,
    output logic                 sda_oe_o,
    input  wire logic [ROWS-1:0] row_i,
    output logic      [COLS-1:0] col_o,
    output logic      [COLS-1:0] col_oe_o,
    input  wire logic            general_input_i,
    input  wire logic            keypad_locked_i,
    input  wire logic            lock_start_i,
    output logic                 int_b_o,
    output logic                 int_oe_o
);
    ////////////////////////////////////////////////////////////////////
    logic [7:0]      cfg_ff;
    logic [4:0]      flag_ff;
    logic [31:0]     tick_ff;
    logic            scan_ff;
    logic [3:0]      col_ff;
    logic [3:0]      settle_ff;
    logic            wake_ff;
    logic [KEYS-1:0] cur_ff;
    logic [KEYS-1:0] raw_ff;
    logic [KEYS-1:0] stable_ff;
    logic            walk_ff;
    logic [6:0]      idx_ff;
    logic            gpi_q_ff;
    logic            gpi_pend_ff;
    logic [7:0]      mem_ff [DEPTH];
    logic [3:0]      rd_ff;
    logic [3:0]      wr_ff;
    logic [3:0]      cnt_ff;
    event_t          buf_ff [2];
    logic [31:0]     hold_ff;
    logic            scl_q_ff;
    logic            sda_q_ff;
    i2c_st_t         ist_ff;
    logic [3:0]      bit_ff;
    logic [7:0]      sr_ff;
    logic [7:0]      ptr_ff;
    logic [7:0]      txd_ff;
    logic            rw_ff;
    logic            sda_drv_ff;

    logic       tick;
    logic       key_vld;
    logic       in_vld;
    logic [7:0] in_code;
    logic       in_rdy;
    logic       out_rdy;
    logic       push;
    logic       pop;
    logic       full;
    logic       wr_en;
    logic       rd_en;
    logic       start;
    logic       stop;
    logic       rise;
    logic       fall;
    logic [7:0] rdata;
    logic       combo;

    assign tick = (tick_ff == 32'(SCAN_CYCLES - 1));
    assign full = (cnt_ff == 4'(DEPTH));
    assign combo = stable_ff[COMBO_A] & stable_ff[COMBO_B]
                 & stable_ff[COMBO_C];

    ////////////////////////////////////////////////////////////////////
    // Scan period divider.
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) tick_ff <= '0;
        else if (tick) tick_ff <= '0;
        else tick_ff <= tick_ff + 32'h1;
    end

    // Wake on a low row while idle; rescan each period while anything is
    // held so that releases also pass two agreeing scans.
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            scan_ff <= 1'b0;
            col_ff <= '0;
            settle_ff <= '0;
            wake_ff <= 1'b0;
            cur_ff <= '0;
            raw_ff <= '0;
        end else if (!scan_ff) begin
            if (|(~row_i)) wake_ff <= 1'b1;
            if (tick && (wake_ff || |stable_ff || |cur_ff)) begin
                scan_ff <= 1'b1;
                wake_ff <= 1'b0;
                // Keep the finished scan whole, so the next tick compares
                // two complete scans and one scan alone accepts nothing.
                raw_ff <= cur_ff;
                col_ff <= '0;
                settle_ff <= '0;
            end
        end else if (settle_ff != SETTLE_CYC) begin
            settle_ff <= settle_ff + 4'h1;
        end else begin
            for (int r = 0; r < ROWS; r++) begin
                cur_ff[r*COLS + int'(col_ff)] <= ~row_i[r];
            end
            settle_ff <= '0;
            if (col_ff == 4'(COLS - 1)) scan_ff <= 1'b0;
            else col_ff <= col_ff + 4'h1;
        end
    end

    // Idle drives every column low; a scan drives only the current one.
    always_comb begin
        col_o = '0;
        for (int c = 0; c < COLS; c++) begin
            col_oe_o[c] = !scan_ff || (col_ff == 4'(c));
        end
    end

    ////////////////////////////////////////////////////////////////////
    // After a scan whose result matches the one before, walk each key
    // that differs from the accepted state and emit one event per key.
    // The walk stalls on a full buffer, so no change is skipped.
    assign key_vld = walk_ff && (raw_ff[idx_ff] != stable_ff[idx_ff]);
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            walk_ff <= 1'b0;
            idx_ff <= '0;
            stable_ff <= '0;
        end else if (!walk_ff) begin
            if (tick && !scan_ff && raw_ff == cur_ff) begin
                walk_ff <= 1'b1;
                idx_ff <= '0;
            end
        end else if (!key_vld || in_rdy) begin
            if (key_vld) stable_ff[idx_ff] <= raw_ff[idx_ff];
            if (idx_ff == 7'(KEYS - 1)) walk_ff <= 1'b0;
            else idx_ff <= idx_ff + 7'h1;
        end
    end

    // Input edges wait until the key walk leaves the buffer free.
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            gpi_q_ff <= 1'b0;
            gpi_pend_ff <= 1'b0;
        end else begin
            gpi_q_ff <= general_input_i;
            if (general_input_i != gpi_q_ff
                && !(keypad_locked_i && cfg_ff[LOCKGPI_BIT])) begin
                gpi_pend_ff <= 1'b1;
            end else if (!key_vld && in_rdy) begin
                gpi_pend_ff <= 1'b0;
            end
        end
    end

    assign in_vld = key_vld || gpi_pend_ff;
    assign in_code = key_vld ? {raw_ff[idx_ff], 7'(idx_ff + 7'h1)}
                             : GPI_CODE;

    ////////////////////////////////////////////////////////////////////
    // Two-entry buffer; it stalls while the host pops the store.
    assign in_rdy = !buf_ff[1].valid;
    assign out_rdy = !rd_en;
    assign push = buf_ff[0].valid && out_rdy;
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            buf_ff[0] <= '0;
            buf_ff[1] <= '0;
        end else begin
            if (push) begin
                buf_ff[0] <= buf_ff[1];
                buf_ff[1] <= '0;
            end
            if (in_vld && in_rdy) begin
                if (!buf_ff[0].valid || (push && !buf_ff[1].valid))
                    buf_ff[0] <= '{1'b1, in_code};
                else buf_ff[1] <= '{1'b1, in_code};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Ten-entry event store. Push and pop never share a cycle.
    assign pop = rd_en && (cnt_ff != 4'h0);
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rd_ff <= '0;
            wr_ff <= '0;
            cnt_ff <= '0;
        end else if (push && (!full || cfg_ff[OVMODE_BIT])) begin
            mem_ff[wr_ff] <= buf_ff[0].code;
            wr_ff <= (wr_ff == 4'(DEPTH - 1)) ? 4'h0 : wr_ff + 4'h1;
            if (full) begin
                rd_ff <= (rd_ff == 4'(DEPTH - 1)) ? 4'h0 : rd_ff + 4'h1;
            end else begin
                cnt_ff <= cnt_ff + 4'h1;
            end
        end else if (pop) begin
            rd_ff <= (rd_ff == 4'(DEPTH - 1)) ? 4'h0 : rd_ff + 4'h1;
            cnt_ff <= cnt_ff - 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Configuration and sticky status. A set in the same cycle as a
    // clear wins; key and input flags stay while the store is not empty.
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cfg_ff <= CFG_RESET;
            flag_ff <= '0;
            hold_ff <= '0;
        end else begin
            if (hold_ff != 32'h0) hold_ff <= hold_ff - 32'h1;
            if (wr_en && ptr_ff == CFG_ADDR) cfg_ff <= sr_ff;
            if (wr_en && ptr_ff == STAT_ADDR) begin
                flag_ff[4:2] <= flag_ff[4:2] & ~sr_ff[4:2];
                if (cnt_ff == 4'h0) begin
                    flag_ff[1:0] <= flag_ff[1:0] & ~sr_ff[1:0];
                end else if (|(sr_ff[1:0] & flag_ff[1:0])
                             && cfg_ff[INTMODE_BIT]) begin
                    hold_ff <= 32'(REARM_CYCLES);
                end
            end
            if (push && buf_ff[0].code == GPI_CODE && cfg_ff[GPIEN_BIT])
                flag_ff[GPI_BIT] <= 1'b1;
            if (push && buf_ff[0].code != GPI_CODE && cfg_ff[KEYIEN_BIT])
                flag_ff[KEY_BIT] <= 1'b1;
            if (push && full && cfg_ff[OVMODE_BIT] && cfg_ff[OVIEN_BIT])
                flag_ff[OVF_BIT] <= 1'b1;
            if (lock_start_i && cfg_ff[LKIEN_BIT])
                flag_ff[LOCK_BIT] <= 1'b1;
            if (combo && walk_ff) flag_ff[COMBO_BIT] <= 1'b1;
        end
    end

    // Interrupt pin is pulled low by enabling the driver.
    assign int_b_o = 1'b0;
    assign int_oe_o = |flag_ff && (hold_ff == 32'h0);

    ////////////////////////////////////////////////////////////////////
    // Serial register port, sampled on the system clock.
    assign start = scl_i && scl_q_ff && sda_q_ff && !sda_i;
    assign stop = scl_i && scl_q_ff && !sda_q_ff && sda_i;
    assign rise = scl_i && !scl_q_ff;
    assign fall = !scl_i && scl_q_ff;
    assign wr_en = fall && bit_ff == 4'h8 && ist_ff == I_WR;
    assign rd_en = rise && bit_ff == 4'h8 && (ist_ff == I_RD ? !sda_i
                 : (ist_ff == I_ADDR && rw_ff)) && ptr_ff == EVT_ADDR;

    always_comb begin
        unique case (ptr_ff)
            CFG_ADDR: rdata = cfg_ff;
            STAT_ADDR: rdata = {3'h0, flag_ff};
            CNT_ADDR: rdata = {4'h0, cnt_ff};
            EVT_ADDR: rdata = (cnt_ff == 4'h0) ? 8'h00 : mem_ff[rd_ff];
            default: rdata = 8'h00;
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            scl_q_ff <= 1'b1;
            sda_q_ff <= 1'b1;
            ist_ff <= I_IDLE;
            bit_ff <= '0;
            sr_ff <= '0;
            ptr_ff <= '0;
            txd_ff <= '0;
            rw_ff <= 1'b0;
            sda_drv_ff <= 1'b0;
        end else begin
            scl_q_ff <= scl_i;
            sda_q_ff <= sda_i;
            if (start) begin
                ist_ff <= I_ADDR;
                bit_ff <= '0;
            end else if (stop) begin
                ist_ff <= I_IDLE;
                sda_drv_ff <= 1'b0;
            end else if (ist_ff != I_IDLE && rise) begin
                if (bit_ff != 4'h8) begin
                    sr_ff <= {sr_ff[6:0], sda_i};
                    bit_ff <= bit_ff + 4'h1;
                end else begin
                    bit_ff <= '0;
                    unique case (ist_ff)
                        I_ADDR: ist_ff <= rw_ff ? I_RD : I_PTR;
                        I_PTR: ist_ff <= I_WR;
                        I_WR: ist_ff <= I_WR;
                        I_RD: if (sda_i) ist_ff <= I_IDLE;
                        default: ist_ff <= I_IDLE;
                    endcase
                    if ((ist_ff == I_ADDR && rw_ff)
                        || (ist_ff == I_RD && !sda_i)) begin
                        txd_ff <= rdata;
                        if (cfg_ff[AUTO_BIT]) ptr_ff <= ptr_ff + 8'h1;
                    end
                end
            end else if (ist_ff != I_IDLE && fall) begin
                if (bit_ff == 4'h8) begin
                    sda_drv_ff <= ist_ff != I_RD
                               && (ist_ff != I_ADDR || sr_ff[7:1] == DEV_ADDR);
                    if (ist_ff == I_ADDR) begin
                        rw_ff <= sr_ff[0];
                        if (sr_ff[7:1] != DEV_ADDR) ist_ff <= I_IDLE;
                    end
                    if (ist_ff == I_PTR) ptr_ff <= sr_ff;
                    if (ist_ff == I_WR && cfg_ff[AUTO_BIT])
                        ptr_ff <= ptr_ff + 8'h1;
                end else if (ist_ff == I_RD) begin
                    sda_drv_ff <= !txd_ff[3'(4'h7 - bit_ff)];
                end else begin
                    sda_drv_ff <= 1'b0;
                end
            end
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe_o = sda_drv_ff;
endmodule : keypad_event_fifo_control
`default_nettype wire

/* File: test/keypad_event_fifo_control_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module keypad_event_fifo_control_chk
    import keypad_pkg::*;
#(
    parameter int SCAN_CYCLES  = SCAN_CYC,
    parameter int REARM_CYCLES = REARM_CYC
) (
    input wire logic            mclk_i,
    input wire logic            rst_b_i,
    input wire logic            scl_i,
    input wire logic            sda_i,
    input wire logic            sda_o,
    input wire logic            sda_oe_o,
    input wire logic [ROWS-1:0] row_i,
    input wire logic [COLS-1:0] col_o,
    input wire logic [COLS-1:0] col_oe_o,
    input wire logic            general_input_i,
    input wire logic            keypad_locked_i,
    input wire logic            lock_start_i,
    input wire logic            int_b_o,
    input wire logic            int_oe_o
);
    // One clock domain, so clock and reset are given once.
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);

    a_col_legal: assert property ($onehot(col_oe_o) || (&col_oe_o))
        else $error("more than one column driven");
    a_col_low: assert property (col_o == '0)
        else $error("column value not low");
    a_col_settle: assert property ($changed(col_oe_o) |=> $stable(col_oe_o) [*3])
        else $error("column dwell too short");
    a_col_dwell: assert property ($onehot(col_oe_o) |-> ##[1:16] $changed(col_oe_o))
        else $error("scan stuck on one column");
    a_int_open: assert property (int_b_o == 1'b0)
        else $error("interrupt value not low");
    a_sda_open: assert property (sda_o == 1'b0)
        else $error("data value not low");
    a_rst_idle: assert property ($rose(rst_b_i) |-> (&col_oe_o) && !int_oe_o && !sda_oe_o)
        else $error("outputs not idle after reset");
    a_sda_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
        else $error("data changed while serial clock high");

    // The main scenarios: a scan, an interrupt and an acknowledge.
    c_scan: cover property ($onehot(col_oe_o));
    c_int: cover property ($rose(int_oe_o));
    c_ack: cover property ($rose(sda_oe_o));
endmodule : keypad_event_fifo_control_chk

bind keypad_event_fifo_control keypad_event_fifo_control_chk #(
    .SCAN_CYCLES(SCAN_CYCLES), .REARM_CYCLES(REARM_CYCLES)
) u_keypad_event_fifo_control_chk (.mclk_i, .rst_b_i, .scl_i, .sda_i,
    .sda_o, .sda_oe_o, .row_i, .col_o, .col_oe_o, .general_input_i,
    .keypad_locked_i, .lock_start_i, .int_b_o, .int_oe_o);
`default_nettype wire

/* File: test/i2c_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model
    import keypad_pkg::*;
(
    input  wire logic mclk_i,
    input  wire logic sda_oe_i,
    output logic      scl_o,
    output logic      sda_o
);
    logic low_ff;
    int   nacks;
    // Pull-up wins unless some party pulls the data line low.
    assign sda_o = !(low_ff || sda_oe_i);
    initial begin
        scl_o = 1'b1;
        low_ff = 1'b0;
        nacks = 0;
    end
    task automatic tk(input int n);
        repeat (n) @(posedge mclk_i);
    endtask : tk
    // Data moves three cycles after the clock falls, clear of the sync.
    task automatic bit_io(input logic b, output logic r);
        low_ff <= !b;
        tk(5);
        scl_o <= 1'b1;
        tk(5);
        r = sda_o;
        scl_o <= 1'b0;
        tk(3);
    endtask : bit_io
    // Start and repeated start share one shape.
    task automatic start();
        low_ff <= 1'b0;
        tk(3);
        scl_o <= 1'b1;
        tk(5);
        low_ff <= 1'b1;
        tk(5);
        scl_o <= 1'b0;
        tk(3);
    endtask : start
    task automatic byte_io(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
    endtask : byte_io
    // Pointer first, then one data byte or up to two read bytes.
    task automatic access(input logic [7:0] p, input logic wr,
                          input logic [7:0] wd, input int n,
                          output logic [15:0] rd);
        logic [8:0] rx;
        start();
        byte_io({DEV_ADDR, 2'b01}, rx);
        nacks += rx[0];
        byte_io({p, 1'b1}, rx);
        nacks += rx[0];
        if (wr) begin
            byte_io({wd, 1'b1}, rx);
            nacks += rx[0];
        end else begin
            start();
            byte_io({DEV_ADDR, 2'b11}, rx);
            nacks += rx[0];
            for (int k = 0; k < n; k++) begin
                byte_io({8'hFF, k == n - 1}, rx);
                rd = {rd[7:0], rx[8:1]};
            end
        end
        low_ff <= 1'b1;
        tk(3);
        scl_o <= 1'b1;
        tk(5);
        low_ff <= 1'b0;
        tk(5);
    endtask : access
endmodule : i2c_host_model
`default_nettype wire

/* File: test/keypad_event_fifo_control_test.sv */
`timescale 1ns/1ps
`default_nettype none
module keypad_event_fifo_control_test
    import keypad_pkg::*;
;
    localparam int SCAN = 400;
    logic            mclk_i, rst_b_i, gin, lk, lks, scl, sda, sda_oe;
    logic            int_oe;
    logic [ROWS-1:0] row;
    logic [COLS-1:0] col_oe;
    logic [KEYS-1:0] pressed;
    logic [15:0]     v;
    int              n_mismatch, n_tests;

    keypad_event_fifo_control #(.SCAN_CYCLES(SCAN), .REARM_CYCLES(200))
    u_keypad_event_fifo_control (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
        .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe), .row_i(row),
        .col_o(), .col_oe_o(col_oe), .general_input_i(gin),
        .keypad_locked_i(lk), .lock_start_i(lks), .int_b_o(),
        .int_oe_o(int_oe));
    i2c_host_model u_i2c_host_model (.mclk_i(mclk_i), .sda_oe_i(sda_oe),
        .scl_o(scl), .sda_o(sda));

    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end
    // A row reads low when a pressed key sits on a driven column.
    always_ff @(posedge mclk_i) begin
        for (int r = 0; r < ROWS; r++) begin
            row[r] <= !(|(pressed[r*COLS +: COLS] & col_oe));
        end
    end
    task automatic print_verdict();
        if (n_mismatch == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        u_i2c_host_model.access(p, 1'b1, d, 0, v);
    endtask : wr
    task automatic rchk(input logic [7:0] p, input logic [7:0] e);
        u_i2c_host_model.access(p, 1'b0, 8'h00, 1, v);
        chk(v[7:0], e);
    endtask : rchk
    // Bounded wait; running out ends the run as a failure.
    task automatic wait_int(input int lim);
        int k;
        k = 0;
        while (int_oe !== 1'b1 && k < lim) begin
            @(posedge mclk_i);
            k++;
        end
        if (k == lim) begin
            n_mismatch++;
            $display("CHECK FAILED %0t interrupt timeout", $time);
            print_verdict();
        end
    endtask : wait_int
    task automatic tog(input int n);
        repeat (n) begin
            gin <= !gin;
            repeat (8) @(posedge mclk_i);
        end
    endtask : tog
    task automatic drain();
        u_i2c_host_model.access(CNT_ADDR, 1'b0, 8'h00, 1, v);
        repeat (int'(v[7:0])) u_i2c_host_model.access(EVT_ADDR, 1'b0,
            8'h00, 1, v);
        rchk(CNT_ADDR, 8'h00);
        wr(STAT_ADDR, 8'h1F);
    endtask : drain
    ////////////////////////////////////////////////////////////////////
    task automatic t_cfg();
        rchk(CFG_ADDR, CFG_RESET);
        rchk(8'h7F, 8'h00);
        wr(CFG_ADDR, 8'h81);
        u_i2c_host_model.access(CFG_ADDR, 1'b0, 8'h00, 2, v);
        chk(v[15:8], 8'h81);
        chk(v[7:0], 8'h00);
        wr(CFG_ADDR, 8'h03);
        u_i2c_host_model.access(CFG_ADDR, 1'b0, 8'h00, 2, v);
        chk(v[7:0], 8'h03);
    endtask : t_cfg
    task automatic t_key();
        pressed[0] <= 1'b1;
        wait_int(4 * SCAN);
        rchk(STAT_ADDR, 8'h01);
        rchk(EVT_ADDR, 8'h81);
        wr(STAT_ADDR, 8'h01);
        chk({7'h00, int_oe}, 8'h00);
        pressed[0] <= 1'b0;
        wait_int(4 * SCAN);
        rchk(EVT_ADDR, 8'h01);
        wr(STAT_ADDR, 8'h01);
    endtask : t_key
    task automatic t_combo();
        pressed[0] <= 1'b1;
        pressed[10] <= 1'b1;
        pressed[20] <= 1'b1;
        repeat (4 * SCAN) @(posedge mclk_i);
        wr(STAT_ADDR, 8'h00);
        u_i2c_host_model.access(STAT_ADDR, 1'b0, 8'h00, 1, v);
        chk(v[7:0] & 8'h10, 8'h10);
        rchk(CNT_ADDR, 8'h03);
        // The flag sets again on every scan while all three keys stay
        // down, so two of them are let go before the clear is checked.
        pressed[10] <= 1'b0;
        pressed[20] <= 1'b0;
        repeat (4 * SCAN) @(posedge mclk_i);
        wr(STAT_ADDR, 8'h10);
        u_i2c_host_model.access(STAT_ADDR, 1'b0, 8'h00, 1, v);
        chk(v[7:0] & 8'h10, 8'h00);
        drain();
    endtask : t_combo
    // Only the overflow enable is on; a key release is the oldest entry,
    // so a wrap shows up as an input code at the head.
    task automatic t_ovf();
        wr(CFG_ADDR, 8'h08);
        pressed[0] <= 1'b0;
        repeat (4 * SCAN) @(posedge mclk_i);
        tog(9);
        rchk(CNT_ADDR, 8'h0A);
        tog(1);
        rchk(CNT_ADDR, 8'h0A);
        rchk(STAT_ADDR, 8'h00);
        wr(CFG_ADDR, 8'h28);
        tog(1);
        rchk(STAT_ADDR, 8'h08);
        rchk(EVT_ADDR, GPI_CODE);
        drain();
        drain();
    endtask : t_ovf
    task automatic t_lock();
        wr(CFG_ADDR, 8'h00);
        lks <= 1'b1;
        @(posedge mclk_i);
        lks <= 1'b0;
        rchk(STAT_ADDR, 8'h00);
        wr(CFG_ADDR, 8'h04);
        lks <= 1'b1;
        @(posedge mclk_i);
        lks <= 1'b0;
        rchk(STAT_ADDR, 8'h04);
        chk({7'h00, int_oe}, 8'h01);
        wr(STAT_ADDR, 8'h04);
        lk <= 1'b1;
        wr(CFG_ADDR, 8'h40);
        tog(1);
        rchk(CNT_ADDR, 8'h00);
        wr(CFG_ADDR, 8'h02);
        tog(1);
        rchk(CNT_ADDR, 8'h01);
        lk <= 1'b0;
        wr(STAT_ADDR, 8'h02);
        chk({7'h00, int_oe}, 8'h01);
        wr(CFG_ADDR, 8'h12);
        wr(STAT_ADDR, 8'h02);
        chk({7'h00, int_oe}, 8'h00);
        wait_int(300);
        drain();
    endtask : t_lock
    ////////////////////////////////////////////////////////////////////
    initial begin
        {rst_b_i, gin, lk, lks} = 4'h0;
        pressed = '0;
        n_mismatch = 0;
        n_tests = 0;
        repeat (20) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        t_cfg();
        t_key();
        t_combo();
        t_ovf();
        t_lock();
        chk(8'(u_i2c_host_model.nacks), 8'h00);
        print_verdict();
    end
endmodule : keypad_event_fifo_control_test
`default_nettype wire
